// File: design/ecg_pkg.sv
// constants and helpers for the echo canceller group control block
package ecg_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRL1  = 8'h00;
    localparam logic [7:0] IDX_CTRL2  = 8'h01;
    localparam logic [7:0] IDX_CTRL3  = 8'h08;
    localparam logic [7:0] IDX_GAINS  = 8'h1C;
    localparam logic [7:0] IDX_B_OFS  = 8'h20;
    localparam logic [7:0] IDX_GROUP  = 8'h40;
    localparam logic [7:0] IDX_STATUS = 8'h41;
    // control 1 bits
    localparam int C1_EXT = 0;
    localparam int C1_BID = 1;
    localparam int C1_ATT = 2;
    localparam int C1_BYP = 3;
    localparam int C1_ADS = 4;
    // control 2 bits
    localparam int C2_RMUTE = 0;
    localparam int C2_SMUTE = 1;
    localparam int C2_NARROWBAND_DETECT_DISABLE = 2;
    localparam int C2_ONDIS = 3;
    // control 3 bit
    localparam int C3_RING = 0;
    // gains fields, three bits each
    localparam int G_RIN  = 0;
    localparam int G_SIN  = 3;
    localparam int G_ROUT = 6;
    localparam int G_SOUT = 9;
    localparam logic [11:0] GAINS_RST = 12'h06DB;
    localparam logic [2:0]  PAD_M12   = 3'h7;
    // pcm quiet codes
    localparam logic [7:0] Q_LIN = 8'h00;
    localparam logic [7:0] Q_SM  = 8'h80;
    localparam logic [7:0] Q_MU  = 8'hFF;
    localparam logic [7:0] Q_A   = 8'hD5;
    // serial timing, counted in rising serial clock edges; read gap counted in frame slots
    localparam logic [3:0]  PULSE_MAX = 4'h4;
    localparam logic [10:0] LOSS_CNT  = 11'h44C;
    localparam int          RD_GAP    = 1;
    typedef enum logic [1:0] {ECG_LIN, ECG_SM, ECG_MU, ECG_A} ecg_fmt_e;
    typedef enum logic [1:0] {ECG_PAR, ECG_BID, ECG_CASC} ecg_cfg_e;
    typedef enum logic [2:0] {
        SEL_NONE, SEL_C1, SEL_C2, SEL_C3, SEL_GAINS, SEL_GROUP, SEL_STATUS
    } ecg_sel_e;

    function automatic logic [7:0] quiet(input logic [1:0] fmt);
        case (fmt)
            2'h0:    quiet = Q_LIN;
            2'h1:    quiet = Q_SM;
            2'h2:    quiet = Q_MU;
            default: quiet = Q_A;
        endcase
    endfunction

    // +9 dB down to -12 dB in 3 dB steps, scale of 128
    function automatic logic [8:0] pad_q7(input logic [2:0] code);
        case (code)
            3'h0:    pad_q7 = 9'h169;
            3'h1:    pad_q7 = 9'h0FF;
            3'h2:    pad_q7 = 9'h0B5;
            3'h3:    pad_q7 = 9'h080;
            3'h4:    pad_q7 = 9'h05B;
            3'h5:    pad_q7 = 9'h040;
            3'h6:    pad_q7 = 9'h02D;
            default: pad_q7 = 9'h020;
        endcase
    endfunction
endpackage

// File: design/ecg_group.sv
// one group of two echo cancellers: registers, pcm streams, muting
//
// Overview of operation
// - ring suppression follows the ring-clear control bit per canceller.
// - tone detection halts adaptation unless its disable bit is set.
// - offset-null filters enabled unless the high-pass disable bit is set.
// - four level pads per canceller, +9 to -12 dB in 3 dB steps, applied in sign-magnitude format only.
// - legacy attenuate bit forces -12 dB at receive input pad in sign-magnitude format.
// - two individually controlled cancellers per group, three configurations.
// - bidirectional only when both cancellers set the bidirectional bit.
// - bidirectional: one timeslot per port, second slot outputs zero code.
// - cascaded: single timeslot per port, second slot outputs quiet code.
// - cascaded selected by first canceller's extended-delay bit only.
// - parallel/cascaded: receive mute quiets filter, output; send mute send.
// - quiet code per format: 0000, 80, FF or D5 hex.
// - bidirectional: first canceller's send_mute quiets the send output only.
// - bypass passes codes unchanged and clears filter coefficients.
// - disable-adaptation freezes coefficients; enable-adaptation updates them.
// - receive delay two frames, send three; bypass two frames both.
// - four tdm streams of 32 channels at 2.048 Mb/s.
// - frame pulse presence and framing format detected automatically.
// - bit boundaries and sampling edges depend on detected framing format.
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ns
module ecg_group (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        serial_bit_clock,
    input  wire logic        frame_pulse,
    input  wire logic        rin_data,
    input  wire logic        sin_data,
    output logic             rout_data,
    output logic             sout_data,
    input  wire logic [1:0]  narrowband_tone_detector,
    output logic      [1:0]  adapt_enable,
    output logic      [1:0]  coeff_clear,
    output logic      [1:0]  ring_suppress_enable,
    output logic      [1:0]  offset_null_on,
    output logic      [1:0]  filter_rin_quiet
);
    // ****************************************
    // registers
    // ****************************************
    logic [4:0]  c1 [2];
    logic [3:0]  c2 [2];
    logic        c3 [2];
    logic [11:0] gn [2];
    logic [3:0]  grp;
    logic [1:0]  fmt;
    logic [4:0]  a_c1 [2];
    logic [3:0]  a_c2 [2];
    logic        a_c3 [2];
    logic [11:0] a_gn [2];
    logic [3:0]  a_grp;
    logic [1:0]  a_fmt;
    logic [1:0]  clr_done;
    logic        present;
    logic        gci;
    ecg_pkg::ecg_cfg_e cfg;

    function automatic ecg_pkg::ecg_sel_e dec(input logic [11:0] a);
        logic [7:0] i;
        i = a[9:2];
        dec = ecg_pkg::SEL_NONE;
        if (a[11:10] == 2'h0 && a[1:0] == 2'h0) begin
            if (i == ecg_pkg::IDX_GROUP)
                dec = ecg_pkg::SEL_GROUP;
            else if (i == ecg_pkg::IDX_STATUS)
                dec = ecg_pkg::SEL_STATUS;
            else if (i[7:6] == 2'h0) begin
                case (i & ~ecg_pkg::IDX_B_OFS)
                    ecg_pkg::IDX_CTRL1: dec = ecg_pkg::SEL_C1;
                    ecg_pkg::IDX_CTRL2: dec = ecg_pkg::SEL_C2;
                    ecg_pkg::IDX_CTRL3: dec = ecg_pkg::SEL_C3;
                    ecg_pkg::IDX_GAINS: dec = ecg_pkg::SEL_GAINS;
                    default:            dec = ecg_pkg::SEL_NONE;
                endcase
            end
        end
    endfunction

    ecg_pkg::ecg_sel_e sel;
    logic              k_sel;
    assign sel    = dec(paddr);
    assign k_sel  = paddr[7];
    assign pready = 1'b1;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int k = 0; k < 2; k++) begin
                c1[k] <= 5'h00;
                c2[k] <= 4'h0;
                c3[k] <= 1'b0;
                gn[k] <= ecg_pkg::GAINS_RST;
            end
            grp <= 4'h0;
            fmt <= 2'h0;
        end else if (psel && penable && pwrite) begin
            case (sel)
                ecg_pkg::SEL_C1:    c1[k_sel] <= pwdata[4:0];
                ecg_pkg::SEL_C2:    c2[k_sel] <= pwdata[3:0];
                ecg_pkg::SEL_C3:    c3[k_sel] <= pwdata[ecg_pkg::C3_RING];
                ecg_pkg::SEL_GAINS: gn[k_sel] <= pwdata[11:0];
                ecg_pkg::SEL_GROUP: begin
                    grp <= pwdata[3:0];
                    fmt <= pwdata[5:4];
                end
                default: ;
            endcase
        end
    end

    // read data captured in the setup cycle, valid in the access cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            pslverr <= (sel == ecg_pkg::SEL_NONE);
            case (sel)
                ecg_pkg::SEL_C1:     prdata <= {27'h0, c1[k_sel]};
                ecg_pkg::SEL_C2:     prdata <= {28'h0, c2[k_sel]};
                ecg_pkg::SEL_C3:     prdata <= {31'h0, c3[k_sel]};
                ecg_pkg::SEL_GAINS:  prdata <= {20'h0, gn[k_sel]};
                ecg_pkg::SEL_GROUP:  prdata <= {26'h0, fmt, grp};
                ecg_pkg::SEL_STATUS:
                    prdata <= {26'h0, cfg, clr_done, gci, present};
                default:             prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ****************************************
    // serial pin sampling and framing
    // ****************************************
    logic [3:0]  sy1;
    logic [3:0]  sy2;
    logic        sclk_d;
    logic        fp_d;
    logic [10:0] fp_cnt;
    logic        pulse_hit;
    logic [9:0]  half;
    logic [9:0]  next_half;
    logic [1:0]  slot;
    logic        rise;
    logic        fall;
    logic        bnd;
    logic        opp;
    logic        fp_act;
    logic        frame_start;
    logic        out_load;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sy1    <= 4'h0;
            sy2    <= 4'h0;
            sclk_d <= 1'b0;
            fp_d   <= 1'b0;
        end else begin
            sy1    <= {sin_data, rin_data, frame_pulse, serial_bit_clock};
            sy2    <= sy1;
            sclk_d <= sy2[0];
            fp_d   <= sy2[1];
        end
    end

    assign rise   = sy2[0] && !sclk_d;
    assign fall   = !sy2[0] && sclk_d;
    assign bnd    = gci ? rise : fall;
    assign opp    = gci ? fall : rise;
    assign fp_act = (sy2[1] == gci);
    assign frame_start = bnd && present && fp_act && !pulse_hit;
    assign next_half   = frame_start ? 10'h000 : half + 10'h001;
    assign out_load    = bnd && next_half[3:0] == 4'h0;

    // a short level between two pulse edges is the pulse itself
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fp_cnt  <= 11'h000;
            present <= 1'b0;
            gci     <= 1'b0;
        end else if (sy2[1] != fp_d) begin
            if (fp_cnt <= {7'h00, ecg_pkg::PULSE_MAX}) begin
                present <= 1'b1;
                gci     <= fp_d;
            end
            fp_cnt <= 11'h000;
        end else if (rise && fp_cnt != ecg_pkg::LOSS_CNT) begin
            fp_cnt <= fp_cnt + 11'h001;
        end else if (fp_cnt == ecg_pkg::LOSS_CNT) begin
            present <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pulse_hit <= 1'b0;
            half      <= 10'h000;
            slot      <= 2'h0;
        end else if (bnd) begin
            pulse_hit <= fp_act;
            half      <= next_half;
            if (frame_start)
                slot <= (slot == 2'h2) ? 2'h0 : slot + 2'h1;
        end
    end

    // ****************************************
    // frame-aligned settings
    // ****************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int k = 0; k < 2; k++) begin
                a_c1[k] <= 5'h00;
                a_c2[k] <= 4'h0;
                a_c3[k] <= 1'b0;
                a_gn[k] <= ecg_pkg::GAINS_RST;
            end
            a_grp    <= 4'h0;
            a_fmt    <= 2'h0;
            clr_done <= 2'h0;
        end else if (frame_start) begin
            a_c1  <= c1;
            a_c2  <= c2;
            a_c3  <= c3;
            a_gn  <= gn;
            a_grp <= grp;
            a_fmt <= fmt;
            for (int k = 0; k < 2; k++)
                clr_done[k] <= a_c1[k][ecg_pkg::C1_BYP]
                               && c1[k][ecg_pkg::C1_BYP];
        end
    end

    always_comb begin
        if (a_c1[0][ecg_pkg::C1_EXT])
            cfg = ecg_pkg::ECG_CASC;
        else if (a_c1[0][ecg_pkg::C1_BID] && a_c1[1][ecg_pkg::C1_BID])
            cfg = ecg_pkg::ECG_BID;
        else
            cfg = ecg_pkg::ECG_PAR;
    end

    // per-canceller controls toward the filter core
    generate
        for (genvar k = 0; k < 2; k++) begin : g_ctl
            logic byp;
            logic rmute;
            assign byp   = a_c1[k][ecg_pkg::C1_BYP];
            assign rmute = a_c2[k][ecg_pkg::C2_RMUTE]
                           && cfg != ecg_pkg::ECG_BID;
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    adapt_enable[k]         <= 1'b0;
                    coeff_clear[k]          <= 1'b0;
                    ring_suppress_enable[k] <= 1'b0;
                    offset_null_on[k]       <= 1'b0;
                    filter_rin_quiet[k]     <= 1'b0;
                end else begin
                    adapt_enable[k] <= !byp
                        && !a_c1[k][ecg_pkg::C1_ADS]
                        && !(narrowband_tone_detector[k]
                             && !a_c2[k][ecg_pkg::C2_NARROWBAND_DETECT_DISABLE]);
                    coeff_clear[k]          <= byp;
                    ring_suppress_enable[k] <= a_c3[k];
                    offset_null_on[k]       <=
                        !a_c2[k][ecg_pkg::C2_ONDIS];
                    filter_rin_quiet[k]     <= rmute;
                end
            end
        end
    endgenerate

    // ****************************************
    // pcm frame stores and outputs
    // ****************************************
    logic [7:0] rin_mem [0:95];
    logic [7:0] sin_mem [0:95];
    logic [7:0] rin_sr;
    logic [7:0] sin_sr;
    logic [1:0] rd_r;
    logic [4:0] och;
    logic [7:0] rout_byte;
    logic [7:0] sout_byte;

    // three slots: receive reads two frames back, send three
    assign rd_r = (slot == 2'h2) ? 2'h0 : slot + 2'(ecg_pkg::RD_GAP);
    assign och  = next_half[8:4];

    always_ff @(posedge clk) begin
        if (opp && half[0]) begin
            rin_sr <= {rin_sr[6:0], sy2[2]};
            sin_sr <= {sin_sr[6:0], sy2[3]};
            if (half[3:1] == 3'h7) begin
                rin_mem[{slot, half[8:4]}] <= {rin_sr[6:0], sy2[2]};
                sin_mem[{slot, half[8:4]}] <= {sin_sr[6:0], sy2[3]};
            end
        end
    end

    function automatic logic [7:0] pad(input logic [7:0] b,
                                       input logic [2:0] code,
                                       input logic [1:0] f);
        logic [15:0] p;
        p = {9'h000, b[6:0]} * {7'h00, ecg_pkg::pad_q7(code)};
        pad = b;
        if (f == ecg_pkg::ECG_SM)
            pad = {b[7], (p[15:14] != 2'h0) ? 7'h7F : p[13:7]};
    endfunction

    always_comb begin
        logic [7:0] r;
        logic [7:0] s;
        logic       k;
        logic [2:0] gr;
        r = rin_mem[{rd_r, och}];
        s = sin_mem[{a_c1[och[0]][ecg_pkg::C1_BYP] ? rd_r : slot, och}];
        k = och[0];
        gr = a_c1[k][ecg_pkg::C1_ATT] ? ecg_pkg::PAD_M12
                                      : a_gn[k][ecg_pkg::G_RIN +: 3];
        rout_byte = r;
        sout_byte = s;
        if (och[4:1] != a_grp) begin
            rout_byte = r;
        end else if (k && cfg != ecg_pkg::ECG_PAR) begin
            rout_byte = ecg_pkg::quiet(a_fmt);
            sout_byte = ecg_pkg::quiet(a_fmt);
        end else if (!a_c1[k][ecg_pkg::C1_BYP]) begin
            rout_byte = pad(pad(r, gr, a_fmt),
                            a_gn[k][ecg_pkg::G_ROUT +: 3], a_fmt);
            sout_byte = pad(pad(s, a_gn[k][ecg_pkg::G_SIN +: 3], a_fmt),
                            a_gn[k][ecg_pkg::G_SOUT +: 3], a_fmt);
            if (a_c2[k][ecg_pkg::C2_RMUTE])
                rout_byte = ecg_pkg::quiet(a_fmt);
            if (a_c2[k][ecg_pkg::C2_SMUTE])
                sout_byte = ecg_pkg::quiet(a_fmt);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rout_data <= 1'b1;
            sout_data <= 1'b1;
        end else if (bnd && !next_half[0]) begin
            rout_data <= rout_byte[~next_half[3:1]];
            sout_data <= sout_byte[~next_half[3:1]];
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_ADAPT_STATE: assert property (
        adapt_enable[0] |-> $past(!a_c1[0][ecg_pkg::C1_BYP]
                                  && !a_c1[0][ecg_pkg::C1_ADS]))
        else $error("adaptation enabled in bypass or frozen state");
    AST_TONE_HALT: assert property (
        narrowband_tone_detector[1] && !a_c2[1][ecg_pkg::C2_NARROWBAND_DETECT_DISABLE]
        && !frame_start |=> !adapt_enable[1])
        else $error("tone did not halt adaptation");
    AST_RING_FOLLOW: assert property (
        $rose(ring_suppress_enable[0]) |-> $past(a_c3[0], 1))
        else $error("ring suppression rose without its control");
    AST_FRAME_ALIGN: assert property (
        !frame_start |=> $stable(a_c1[0]) && $stable(a_c2[1]))
        else $error("settings changed away from a frame boundary");
    AST_BID_ZERO: assert property (
        out_load && och == {a_grp, 1'b1} && cfg == ecg_pkg::ECG_BID
        |-> rout_byte == ecg_pkg::quiet(a_fmt))
        else $error("second slot not zero code in bidirectional mode");
    AST_CASC_QUIET: assert property (
        out_load && och == {a_grp, 1'b1} && cfg == ecg_pkg::ECG_CASC
        |-> sout_byte == ecg_pkg::quiet(a_fmt))
        else $error("second slot not quiet in cascaded mode");
    AST_RMUTE: assert property (
        out_load && och == {a_grp, 1'b0} && a_c2[0][ecg_pkg::C2_RMUTE]
        && !a_c1[0][ecg_pkg::C1_BYP]
        |-> rout_byte == ecg_pkg::quiet(a_fmt))
        else $error("receive mute did not quiet output");
    AST_BID_SMUTE: assert property (
        out_load && och == {a_grp, 1'b0} && cfg == ecg_pkg::ECG_BID
        && a_c2[0][ecg_pkg::C2_SMUTE] && !a_c1[0][ecg_pkg::C1_BYP]
        |-> sout_byte == ecg_pkg::quiet(a_fmt))
        else $error("send mute did not quiet output");
    AST_BYPASS_PASS: assert property (
        out_load && och == {a_grp, 1'b0} && a_c1[0][ecg_pkg::C1_BYP]
        |-> rout_byte == rin_mem[{rd_r, och}])
        else $error("bypass altered receive code");

    CV_FRAME: cover property (frame_start && present);
    CV_GCI: cover property (frame_start && gci);
    CV_CASC: cover property (out_load && cfg == ecg_pkg::ECG_CASC);
    CV_BID: cover property (out_load && cfg == ecg_pkg::ECG_BID);
endmodule

// File: verification/ecg_tdm_model.sv
// tdm highway model: bit clock, frame pulse, input streams, output capture
`timescale 1ns/1ns
module ecg_tdm_model (
    output logic        serial_bit_clock,
    output logic        frame_pulse_n,
    output logic        rin_data,
    output logic        sin_data,
    input  wire logic   rout_data,
    input  wire logic   sout_data,
    output logic [7:0]  rout0,
    output logic [7:0]  rout1,
    output logic [7:0]  sout0,
    output logic [7:0]  sout1,
    output logic [15:0] cap_frame
);
    logic [8:0]  hc;
    logic [15:0] frame;
    logic [7:0]  rb;
    logic [7:0]  sb;
    logic [15:0] rsh;
    logic [15:0] ssh;

    // ****
    // free-running bit clock, half-cell count, 256 bits a frame
    // ****
    initial begin
        hc = 9'h1FF;
        frame = 16'hFFFF;
        frame_pulse_n = 1'b1;
        rin_data = 1'b1;
        sin_data = 1'b1;
        cap_frame = 16'h0000;
        serial_bit_clock = 1'b1;
        forever #32 serial_bit_clock = ~serial_bit_clock;
    end

    always @(negedge serial_bit_clock) begin
        hc = hc + 9'h001;
        if (hc == 9'h000) begin
            frame = frame + 16'h0001;
        end
        if (!hc[0]) begin
            rb = (hc[8:4] == 5'h00) ? frame[7:0] :
                 (hc[8:4] == 5'h01) ? ~frame[7:0] : 8'hA5;
            sb = (hc[8:4] == 5'h00) ? frame[7:0] + 8'h40 :
                 (hc[8:4] == 5'h01) ? frame[7:0] ^ 8'h55 : 8'h5A;
            rin_data = rb[~hc[3:1]];
            sin_data = sb[~hc[3:1]];
        end
    end

    always @(posedge serial_bit_clock) begin
        frame_pulse_n = (hc != 9'h1FF);
        if (hc[0]) begin
            rsh = {rsh[14:0], rout_data};
            ssh = {ssh[14:0], sout_data};
            if (hc[8:1] == 8'h0F) begin
                rout0 = rsh[15:8];
                rout1 = rsh[7:0];
                sout0 = ssh[15:8];
                sout1 = ssh[7:0];
                cap_frame = frame;
            end
        end
    end
endmodule

// File: verification/ecg_group_tb.sv
// self-checking bench for the echo canceller group control block
`timescale 1ns/1ns
`define CHK(a, b) begin \
    tests_run++; \
    if ((a) !== (b)) begin \
        bad_count++; \
        $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); \
    end \
end
module ecg_group_tb;
    logic        clk;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sclk;
    logic        fp_n;
    logic        rin_d;
    logic        sin_d;
    logic        rout_d;
    logic        sout_d;
    logic [1:0]  tone = 2'b00;
    logic [1:0]  adapt;
    logic [1:0]  cclr;
    logic [1:0]  ring;
    logic [1:0]  onull;
    logic [1:0]  rquiet;
    logic [7:0]  rout0;
    logic [7:0]  rout1;
    logic [7:0]  sout0;
    logic [7:0]  sout1;
    logic [15:0] cap_frame;
    logic [7:0]  f;
    int          bad_count = 0;
    int          tests_run = 0;

    ecg_group DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .serial_bit_clock(sclk),
        .frame_pulse(fp_n), .rin_data(rin_d), .sin_data(sin_d),
        .rout_data(rout_d), .sout_data(sout_d),
        .narrowband_tone_detector(tone), .adapt_enable(adapt),
        .coeff_clear(cclr), .ring_suppress_enable(ring),
        .offset_null_on(onull), .filter_rin_quiet(rquiet));

    ecg_tdm_model PEER (.serial_bit_clock(sclk), .frame_pulse_n(fp_n),
        .rin_data(rin_d), .sin_data(sin_d), .rout_data(rout_d),
        .sout_data(sout_d), .rout0(rout0), .rout1(rout1), .sout0(sout0),
        .sout1(sout1), .cap_frame(cap_frame));

    // ****
    // clock, bus tasks and checks
    // ****
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    function automatic logic [11:0] ra(input logic [7:0] i, input logic b);
        ra = {2'b00, i | {2'b00, b, 5'h00}, 2'b00};
    endfunction

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] m,
                         input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        `CHK(r & m, x)
        `CHK(e, xe)
    endtask

    task automatic setup(input logic [31:0] g, c1a, c1b, c2a, c2b, c3a);
        wr(ra(ecg_pkg::IDX_GROUP, 1'b0), g);
        wr(ra(ecg_pkg::IDX_CTRL1, 1'b0), c1a);
        wr(ra(ecg_pkg::IDX_CTRL1, 1'b1), c1b);
        wr(ra(ecg_pkg::IDX_CTRL2, 1'b0), c2a);
        wr(ra(ecg_pkg::IDX_CTRL2, 1'b1), c2b);
        wr(ra(ecg_pkg::IDX_CTRL3, 1'b0), c3a);
    endtask

    task automatic frames(input int n);
        repeat (n) @(cap_frame);
        @(posedge clk);
        f = cap_frame[7:0];
    endtask

    task automatic slots(input logic [7:0] r0, r1, s0, s1);
        `CHK(rout0, r0)
        `CHK(rout1, r1)
        `CHK(sout0, s0)
        `CHK(sout1, s1)
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ****
    // scenarios
    // ****
    task automatic t_reset();
        for (int s = 0; s < 2; s++) begin
            rdchk(ra(ecg_pkg::IDX_CTRL1, s[0]), '1, 32'h0, 1'b0);
            rdchk(ra(ecg_pkg::IDX_CTRL2, s[0]), '1, 32'h0, 1'b0);
            rdchk(ra(ecg_pkg::IDX_CTRL3, s[0]), '1, 32'h0, 1'b0);
            rdchk(ra(ecg_pkg::IDX_GAINS, s[0]), '1,
                  {20'h0_0000, ecg_pkg::GAINS_RST}, 1'b0);
        end
        rdchk(12'h008, '1, 32'h0000_0000, 1'b1);
        $display("test reset done");
    endtask

    task automatic t_parallel();
        tone <= 2'b01;
        setup(32'h0, 32'h2, 32'h0, 32'h0, 32'h2, 32'h0);
        frames(6);
        rdchk(12'h104, 32'h33, 32'h01, 1'b0);
        rdchk(12'h000, '1, 32'h2, 1'b0);
        slots(f - 8'd2, ~(f - 8'd2), f - 8'd3 + 8'h40, 8'h00);
        `CHK(adapt, 2'b10)
        `CHK(onull, 2'b11)
        `CHK(ring, 2'b00)
        $display("test parallel done");
    endtask

    task automatic t_cascade();
        tone <= 2'b11;
        setup(32'h10, 32'h1, 32'h0, 32'h1, 32'h4, 32'h1);
        frames(4);
        rdchk(12'h104, 32'h30, 32'h20, 1'b0);
        slots(8'h80, 8'h80, f - 8'd3 + 8'h40, 8'h80);
        `CHK(rquiet[0], 1'b1)
        `CHK(adapt, 2'b10)
        `CHK(ring, 2'b01)
        $display("test cascade done");
    endtask

    task automatic t_bidir();
        tone <= 2'b00;
        // gains stay at 0 dB in this mode
        setup(32'h30, 32'h12, 32'h2, 32'hA, 32'h0, 32'h0);
        frames(4);
        rdchk(12'h104, 32'h30, 32'h10, 1'b0);
        slots(f - 8'd2, 8'hD5, 8'hD5, 8'hD5);
        `CHK(adapt, 2'b10)
        `CHK(onull, 2'b10)
        $display("test bidirectional done");
    endtask

    task automatic t_bypass();
        setup(32'h20, 32'h8, 32'h0, 32'h0, 32'h1, 32'h0);
        frames(4);
        rdchk(12'h104, 32'h3C, 32'h04, 1'b0);
        slots(f - 8'd2, 8'hFF, f - 8'd2 + 8'h40,
              (f - 8'd3) ^ 8'h55);
        `CHK(cclr, 2'b01)
        `CHK(rquiet, 2'b10)
        $display("test bypass done");
    endtask

    task automatic t_pads();
        logic [7:0] b;
        logic [7:0] s;
        setup(32'h10, 32'h4, 32'h0, 32'h0, 32'h0, 32'h0);
        wr(ra(ecg_pkg::IDX_GAINS, 1'b1), 32'h0000_06EB);
        frames(4);
        b = f - 8'd2;
        s = (f - 8'd3) ^ 8'h55;
        `CHK(rout0, {b[7], 2'b00, b[6:2]})
        `CHK(rout1, ~b)
        `CHK(sout0, f - 8'd3 + 8'h40)
        `CHK(sout1, {s[7], 1'b0, s[6:1]})
        $display("test pads done");
    endtask

    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_parallel();
        t_cascade();
        t_bidir();
        t_bypass();
        t_pads();
        test_done();
    end

    initial begin
        #900000;
        bad_count++;
        test_done();
    end
endmodule
